// [verilog/evh_event_handler.v]
// Overview of operation
// - Eight sources; seven-four high, three-zero low
// - Enabled rising edge sets sticky flag
// - Write one clears flag; zero keeps
// - Per-source enable bits, reset to zero
// - Top code reports highest flag, else ff
// - Summary bit1 high group, bit0 low
// - Sources sampled by system clock, flag held
// - Each group drives one core event line
// - Reset clears flags, enables; code ff
`timescale 1ns/10ps
`include "evh_defines.vh"

module evh_event_handler #(
   parameter N_SRC = 8,
   parameter ADDR_W = 8
) (
   // Clock and reset
   input wire i_clk,
   input wire i_nrst,
   // Event sources
   input wire [N_SRC-1:0] i_event_src,
   // Core event lines
   output wire o_core_event_line_zero,
   output wire o_core_event_line_one,
   // Interrupt
   output wire o_irq,
   // AXI4-Lite write address
   input wire [ADDR_W-1:0] i_s_axi_awaddr,
   input wire i_s_axi_awvalid,
   output wire o_s_axi_awready,
   // AXI4-Lite write data
   input wire [31:0] i_s_axi_wdata,
   input wire [3:0] i_s_axi_wstrb,
   input wire i_s_axi_wvalid,
   output wire o_s_axi_wready,
   // AXI4-Lite write response
   output reg [1:0] o_s_axi_bresp,
   output reg o_s_axi_bvalid,
   input wire i_s_axi_bready,
   // AXI4-Lite read address
   input wire [ADDR_W-1:0] i_s_axi_araddr,
   input wire i_s_axi_arvalid,
   output wire o_s_axi_arready,
   // AXI4-Lite read data
   output reg [31:0] o_s_axi_rdata,
   output reg [1:0] o_s_axi_rresp,
   output reg o_s_axi_rvalid,
   input wire i_s_axi_rready
);

   // Upper half of the sources is the high group
   localparam HALF = N_SRC / 2;

   // State
   reg [N_SRC-1:0] sync1_q;
   reg [N_SRC-1:0] sync2_q;
   reg [N_SRC-1:0] prev_q;
   reg [N_SRC-1:0] flags_q;
   wire [N_SRC-1:0] flags_d;
   reg [N_SRC-1:0] enables_q;
   reg [1:0] irq_status_q;
   reg [1:0] irq_status_d;
   reg [1:0] irq_mask_q;
   reg [7:0] top_code_q;
   wire [7:0] top_code_d;
   reg [1:0] summary_q;
   reg aw_held_q;
   reg [ADDR_W-1:0] awaddr_q;
   reg w_held_q;
   reg [31:0] wdata_q;
   reg [3:0] wstrb_q;

   // Combinational terms
   wire [N_SRC-1:0] rise;
   wire high_any;
   wire low_any;
   wire aw_take;
   wire w_take;
   wire wr_go;
   wire [ADDR_W-1:0] wr_addr;
   wire [31:0] wr_data;
   wire [3:0] wr_strb;
   wire ar_take;
   reg [N_SRC-1:0] clr_mask;
   reg [1:0] irq_clr;
   reg [31:0] rd_data;
   reg rd_ok;
   reg wr_ok;
   wire high_set;
   wire low_set;
   wire high_next;
   wire low_next;
   wire [7:0] code_chain [0:N_SRC];
   wire wr_lane0;

   // Two-stage synchroniser, edge seen on second stage only
   always @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         sync1_q <= {N_SRC{1'b0}};
         sync2_q <= {N_SRC{1'b0}};
         prev_q <= {N_SRC{1'b0}};
      end
      else
      begin
         sync1_q <= i_event_src;
         sync2_q <= sync1_q;
         prev_q <= sync2_q;
      end
   end

   // Rising edge gated by enable
   genvar g;
   generate
      for (g = 0; g < N_SRC; g = g + 1)
      begin : gen_edge
         assign rise[g] = sync2_q[g] & ~prev_q[g] & enables_q[g];
      end
   endgenerate

   // Write channel: address and data accepted in either order
   assign o_s_axi_awready = !aw_held_q && !o_s_axi_bvalid;
   assign o_s_axi_wready = !w_held_q && !o_s_axi_bvalid;
   assign aw_take = i_s_axi_awvalid && o_s_axi_awready;
   assign w_take = i_s_axi_wvalid && o_s_axi_wready;
   assign wr_go = (aw_held_q || aw_take) && (w_held_q || w_take);
   assign wr_addr = aw_held_q ? awaddr_q : i_s_axi_awaddr;
   assign wr_data = w_held_q ? wdata_q : i_s_axi_wdata;
   assign wr_strb = w_held_q ? wstrb_q : i_s_axi_wstrb;
   // Only byte lane zero carries register bits
   assign wr_lane0 = wr_strb[0];

   // Write decode: clears act in the accept cycle
   always @*
   begin
      clr_mask = {N_SRC{1'b0}};
      irq_clr = 2'b00;
      wr_ok = 1'b1;
      if (!wr_go)
         wr_ok = 1'b1;
      else if (wr_addr == `EVH_ADDR_FLAGS)
      begin
         if (wr_strb[0])
            clr_mask = wr_data[N_SRC-1:0];
      end
      else if (wr_addr == `EVH_ADDR_ENABLES)
         wr_ok = 1'b1;
      else if (wr_addr == `EVH_ADDR_IRQ_STATUS)
      begin
         if (wr_strb[0])
            irq_clr = wr_data[1:0];
      end
      else if (wr_addr == `EVH_ADDR_IRQ_MASK)
         wr_ok = 1'b1;
      else if (wr_addr == `EVH_ADDR_TOP_CODE || wr_addr == `EVH_ADDR_SUMMARY)
         wr_ok = 1'b1;
      // Unmapped addresses answer with an error
      else
         wr_ok = 1'b0;
   end

   // Handshake state; the response waits for bready
   always @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         awaddr_q <= {ADDR_W{1'b0}};
         wdata_q <= 32'h00000000;
         wstrb_q <= 4'h0;
         o_s_axi_bvalid <= 1'b0;
         o_s_axi_bresp <= `EVH_RESP_OKAY;
      end
      else
      begin
         if (wr_go)
         begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            o_s_axi_bvalid <= 1'b1;
            o_s_axi_bresp <= wr_ok ? `EVH_RESP_OKAY : `EVH_RESP_SLVERR;
         end
         else
         begin
            if (aw_take)
            begin
               aw_held_q <= 1'b1;
               awaddr_q <= i_s_axi_awaddr;
            end
            if (w_take)
            begin
               w_held_q <= 1'b1;
               wdata_q <= i_s_axi_wdata;
               wstrb_q <= i_s_axi_wstrb;
            end
            if (o_s_axi_bvalid && i_s_axi_bready)
               o_s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Writable registers, kept apart from the handshake state
   always @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         enables_q <= `EVH_ENABLES_RST;
         irq_mask_q <= 2'b00;
      end
      else if (wr_go && wr_lane0)
      begin
         if (wr_addr == `EVH_ADDR_ENABLES)
            enables_q <= wr_data[N_SRC-1:0];
         else if (wr_addr == `EVH_ADDR_IRQ_MASK)
            irq_mask_q <= wr_data[1:0];
      end
   end

   // Per-source sticky flag: a new edge outranks a clear in the same cycle
   generate
      for (g = 0; g < N_SRC; g = g + 1)
      begin : gen_flag
         assign flags_d[g] = (flags_q[g] & ~clr_mask[g]) | rise[g];
      end
   endgenerate

   // Group activity for the level summary and interrupt status
   assign high_set = |rise[N_SRC-1:HALF];
   assign low_set = |rise[HALF-1:0];
   assign high_next = |flags_d[N_SRC-1:HALF];
   assign low_next = |flags_d[HALF-1:0];

   // Interrupt status: as with the flags, a set beats a clear
   always @*
   begin
      irq_status_d = irq_status_q & ~irq_clr;
      if (high_set)
         irq_status_d[`EVH_SUM_HIGH_BIT] = 1'b1;
      if (low_set)
         irq_status_d[`EVH_SUM_LOW_BIT] = 1'b1;
   end

   // Priority chain: a higher index overrides every lower stage
   assign code_chain[0] = `EVH_TOP_CODE_NONE;
   generate
      for (g = 0; g < N_SRC; g = g + 1)
      begin : gen_prio
         localparam [7:0] IDX = g;
         assign code_chain[g+1] = flags_d[g] ? IDX : code_chain[g];
      end
   endgenerate
   // Taken from next-flag value so code and flags change on one edge
   assign top_code_d = code_chain[N_SRC];

   // Sticky state
   always @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         flags_q <= `EVH_FLAGS_RST;
         irq_status_q <= 2'b00;
      end
      else
      begin
         flags_q <= flags_d;
         irq_status_q <= irq_status_d;
      end
   end

   // Read-only views, registered together with the flags
   always @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         top_code_q <= `EVH_TOP_CODE_NONE;
         summary_q <= 2'b00;
      end
      else
      begin
         top_code_q <= top_code_d;
         summary_q[`EVH_SUM_HIGH_BIT] <= high_next;
         summary_q[`EVH_SUM_LOW_BIT] <= low_next;
      end
   end

   assign high_any = summary_q[`EVH_SUM_HIGH_BIT];
   assign low_any = summary_q[`EVH_SUM_LOW_BIT];
   // Line zero serves the high group
   assign o_core_event_line_zero = high_any;
   assign o_core_event_line_one = low_any;
   // Level output; it drops only when status is cleared or masked
   assign o_irq = |(irq_status_q & irq_mask_q);

   // Read channel: one read in flight
   assign o_s_axi_arready = !o_s_axi_rvalid;
   assign ar_take = i_s_axi_arvalid && o_s_axi_arready;

   // Read decode on the live address, taken with the request
   always @*
   begin
      rd_data = 32'h00000000;
      rd_ok = 1'b1;
      if (i_s_axi_araddr == `EVH_ADDR_FLAGS)
         rd_data[N_SRC-1:0] = flags_q;
      else if (i_s_axi_araddr == `EVH_ADDR_ENABLES)
         rd_data[N_SRC-1:0] = enables_q;
      else if (i_s_axi_araddr == `EVH_ADDR_TOP_CODE)
         rd_data[7:0] = top_code_q;
      else if (i_s_axi_araddr == `EVH_ADDR_SUMMARY)
         rd_data[1:0] = summary_q;
      else if (i_s_axi_araddr == `EVH_ADDR_IRQ_STATUS)
         rd_data[1:0] = irq_status_q;
      else if (i_s_axi_araddr == `EVH_ADDR_IRQ_MASK)
         rd_data[1:0] = irq_mask_q;
      else
         rd_ok = 1'b0;
   end

   // Read data held until rready
   always @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         o_s_axi_rvalid <= 1'b0;
         o_s_axi_rdata <= 32'h00000000;
         o_s_axi_rresp <= `EVH_RESP_OKAY;
      end
      else if (ar_take)
      begin
         o_s_axi_rvalid <= 1'b1;
         o_s_axi_rdata <= rd_data;
         o_s_axi_rresp <= rd_ok ? `EVH_RESP_OKAY : `EVH_RESP_SLVERR;
      end
      else if (o_s_axi_rvalid && i_s_axi_rready)
         o_s_axi_rvalid <= 1'b0;
   end

endmodule

// [verilog/evh_defines.vh]
`ifndef EVH_DEFINES_VH
`define EVH_DEFINES_VH
// Register byte addresses
`define EVH_ADDR_FLAGS 8'h00
`define EVH_ADDR_ENABLES 8'h04
`define EVH_ADDR_TOP_CODE 8'h08
`define EVH_ADDR_SUMMARY 8'h0c
`define EVH_ADDR_IRQ_STATUS 8'h10
`define EVH_ADDR_IRQ_MASK 8'h14
// Reset values
`define EVH_FLAGS_RST 8'h00
`define EVH_ENABLES_RST 8'h00
`define EVH_TOP_CODE_NONE 8'hff
`define EVH_IRQ_RST 8'h00
// Summary field positions
`define EVH_SUM_HIGH_BIT 1
`define EVH_SUM_LOW_BIT 0
// AXI responses
`define EVH_RESP_OKAY 2'b00
`define EVH_RESP_SLVERR 2'b10
`endif

// [bench/evh_src_model.sv]
`timescale 1ns/10ps
module evh_src_model (
   input wire i_clk,
   input wire [7:0] i_fire,
   input wire i_halt,
   input wire i_ev_high,
   input wire i_ev_low,
   output logic [7:0] o_src,
   output logic o_halted,
   output logic o_jev_take
);
   initial o_src = 8'h00;
   initial o_halted = 1'b0;
   // Core stub: halt ends on any event line, program flow simply resumes
   always @(posedge i_clk)
      if (i_halt)
         o_halted <= 1'b1;
      else if (i_ev_high || i_ev_low)
         o_halted <= 1'b0;
   // Jump on event is taken only while a core event flag is up
   assign o_jev_take = i_ev_high || i_ev_low;
   // Registered, so source edges follow fire by one clock and change on the rising edge
   always @(posedge i_clk)
      o_src <= i_fire;
endmodule

// [bench/evh_chk_sva.sv]
`timescale 1ns/10ps
module evh_chk (
   input wire i_clk,
   input wire i_nrst,
   input wire [7:0] i_event_src,
   input wire o_core_event_line_zero,
   input wire o_core_event_line_one,
   input wire [7:0] i_s_axi_araddr,
   input wire i_s_axi_awvalid,
   input wire o_s_axi_awready,
   input wire i_s_axi_wvalid,
   input wire o_s_axi_wready,
   input wire o_s_axi_bvalid,
   input wire i_s_axi_arvalid,
   input wire o_s_axi_arready,
   input wire o_s_axi_rvalid,
   input wire [31:0] o_s_axi_rdata
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   property p_hs;
      $rose(o_core_event_line_zero) |-> $past(|i_event_src[7:4], 3);
   endproperty
   a_hs: assert property (p_hs) else $error("high line rose alone");
   property p_ls;
      $rose(o_core_event_line_one) |-> $past(|i_event_src[3:0], 3);
   endproperty
   a_ls: assert property (p_ls) else $error("low line rose alone");
   property p_hc;
      $fell(o_core_event_line_zero) |-> o_s_axi_bvalid;
   endproperty
   a_hc: assert property (p_hc) else $error("high line fell alone");
   property p_lc;
      $fell(o_core_event_line_one) |-> o_s_axi_bvalid;
   endproperty
   a_lc: assert property (p_lc) else $error("low line fell alone");
   property p_wa;
      i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready |=> o_s_axi_bvalid;
   endproperty
   a_wa: assert property (p_wa) else $error("no write answer");
   property p_ra;
      i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid;
   endproperty
   a_ra: assert property (p_ra) else $error("no read answer");
   property p_br;
      o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready;
   endproperty
   a_br: assert property (p_br) else $error("write taken during answer");
   property p_tn;
      o_s_axi_rvalid && $past(i_s_axi_arvalid && o_s_axi_arready && i_s_axi_araddr == 8'h08)
         && !$past(o_core_event_line_zero || o_core_event_line_one) |-> o_s_axi_rdata == 32'hff;
   endproperty
   a_tn: assert property (p_tn) else $error("top code not ff");
endmodule
bind evh_event_handler evh_chk u_chk (.*);

// [bench/evh_event_handler_tb_top.sv]
`timescale 1ns/10ps
`include "evh_defines.vh"
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin miscompares++; \
   $display("ERROR %s exp %h got %h", n, e, s); end end
module evh_event_handler_tb_top;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] fire = 8'h00;
   logic [7:0] aa = 8'h00;
   logic [7:0] ra = 8'h00;
   logic [31:0] wd = 32'h0;
   logic awv = 1'b0;
   logic wv = 1'b0;
   logic arv = 1'b0;
   logic halt = 1'b0;
   logic halted, jump_on_event_instruction;
   logic [7:0] src;
   logic l0, l1, irq, awr, wr_rdy, bv, arr, rv;
   logic [1:0] br, rr;
   logic [31:0] rdat;
   int miscompares = 0;
   int samples_checked = 0;
   initial forever #5 clk = ~clk;
   evh_src_model u_src (.i_clk(clk), .i_fire(fire), .i_halt(halt), .i_ev_high(l0),
      .i_ev_low(l1), .o_src(src), .o_halted(halted), .o_jev_take(jump_on_event_instruction));
   evh_event_handler u_dut (.i_clk(clk), .i_nrst(nrst), .i_event_src(src),
      .o_core_event_line_zero(l0), .o_core_event_line_one(l1), .o_irq(irq),
      .i_s_axi_awaddr(aa), .i_s_axi_awvalid(awv), .o_s_axi_awready(awr),
      .i_s_axi_wdata(wd), .i_s_axi_wstrb(4'hf), .i_s_axi_wvalid(wv), .o_s_axi_wready(wr_rdy),
      .o_s_axi_bresp(br), .o_s_axi_bvalid(bv), .i_s_axi_bready(1'b1),
      .i_s_axi_araddr(ra), .i_s_axi_arvalid(arv), .o_s_axi_arready(arr),
      .o_s_axi_rdata(rdat), .o_s_axi_rresp(rr), .o_s_axi_rvalid(rv), .i_s_axi_rready(1'b1));
   task automatic final_report;
      if (miscompares == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Sample at the falling edge, act after the rising one
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      logic ta, tw;
      aa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      for (n = 0; n < 20; n++)
      begin
         @(negedge clk);
         ta = awv & awr;
         tw = wv & wr_rdy;
         if (bv === 1'b1)
         begin
            `CHK("bresp", `EVH_RESP_OKAY, br)
            @(posedge clk);
            return;
         end
         @(posedge clk);
         if (ta) awv <= 1'b0;
         if (tw) wv <= 1'b0;
      end
      miscompares++;
      final_report();
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      int n;
      logic t;
      ra <= a;
      arv <= 1'b1;
      for (n = 0; n < 20; n++)
      begin
         @(negedge clk);
         t = arv & arr;
         if (rv === 1'b1)
         begin
            `CHK("rdata", e, rdat)
            `CHK("rresp", er, rr)
            @(posedge clk);
            return;
         end
         @(posedge clk);
         if (t) arv <= 1'b0;
      end
      miscompares++;
      final_report();
   endtask
   task automatic pulse(input logic [7:0] m);
      fire <= m;
      repeat (4) @(posedge clk);
      fire <= 8'h00;
      repeat (10) @(posedge clk);
   endtask
   task automatic t_reset;
      rd(`EVH_ADDR_FLAGS, 32'h0, `EVH_RESP_OKAY);
      rd(`EVH_ADDR_ENABLES, 32'h0, `EVH_RESP_OKAY);
      rd(`EVH_ADDR_TOP_CODE, 32'hff, `EVH_RESP_OKAY);
      rd(`EVH_ADDR_SUMMARY, 32'h0, `EVH_RESP_OKAY);
      rd(8'h20, 32'h0, `EVH_RESP_SLVERR);
   endtask
   task automatic t_gate;
      pulse(8'h80);
      rd(`EVH_ADDR_FLAGS, 32'h0, `EVH_RESP_OKAY);
      wr(`EVH_ADDR_ENABLES, 32'hff);
      rd(`EVH_ADDR_ENABLES, 32'hff, `EVH_RESP_OKAY);
      wr(`EVH_ADDR_TOP_CODE, 32'h0);
      rd(`EVH_ADDR_TOP_CODE, 32'hff, `EVH_RESP_OKAY);
   endtask
   task automatic t_each;
      int k;
      logic [7:0] m;
      for (k = 0; k < 8; k++)
      begin
         m = 8'h01 << k;
         pulse(m);
         rd(`EVH_ADDR_FLAGS, {24'h0, m}, `EVH_RESP_OKAY);
         rd(`EVH_ADDR_TOP_CODE, 32'(k), `EVH_RESP_OKAY);
         rd(`EVH_ADDR_SUMMARY, {30'h0, k > 3, k < 4}, `EVH_RESP_OKAY);
         `CHK("lines", {k > 3, k < 4}, {l0, l1})
         wr(`EVH_ADDR_FLAGS, {24'h0, ~m});
         rd(`EVH_ADDR_FLAGS, {24'h0, m}, `EVH_RESP_OKAY);
         wr(`EVH_ADDR_FLAGS, {24'h0, m});
         rd(`EVH_ADDR_TOP_CODE, 32'hff, `EVH_RESP_OKAY);
      end
   endtask
   task automatic t_prio;
      pulse(8'h81);
      rd(`EVH_ADDR_TOP_CODE, 32'h7, `EVH_RESP_OKAY);
      wr(`EVH_ADDR_FLAGS, 32'h80);
      rd(`EVH_ADDR_TOP_CODE, 32'h0, `EVH_RESP_OKAY);
      wr(`EVH_ADDR_FLAGS, 32'h01);
   endtask
   task automatic t_irq;
      `CHK("irq masked", 1'b0, irq)
      wr(`EVH_ADDR_IRQ_MASK, 32'h3);
      `CHK("irq", 1'b1, irq)
      rd(`EVH_ADDR_IRQ_STATUS, 32'h3, `EVH_RESP_OKAY);
      wr(`EVH_ADDR_IRQ_STATUS, 32'h3);
      `CHK("irq cleared", 1'b0, irq)
   endtask
   task automatic t_core;
      halt <= 1'b1;
      @(posedge clk);
      halt <= 1'b0;
      repeat (3) @(posedge clk);
      `CHK("halted", 1'b1, halted)
      `CHK("jev idle", 1'b0, jump_on_event_instruction)
      pulse(8'h10);
      `CHK("woke", 1'b0, halted)
      `CHK("jev", 1'b1, jump_on_event_instruction)
      wr(`EVH_ADDR_FLAGS, 32'h10);
      rd(`EVH_ADDR_FLAGS, 32'h0, `EVH_RESP_OKAY);
   endtask
   initial
   begin
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      t_reset();
      t_gate();
      t_each();
      t_prio();
      t_irq();
      t_core();
      final_report();
   end
endmodule
